// file: hw/card_regs_pkg.sv
package card_regs_pkg;

	// Printed offsets are not multiples of four: kept as indices, byte address = 4 * index
	localparam logic [7:0] CARD_CONTROL_IDX = 8'h91;
	localparam logic [7:0] DEVICE_CONTROL_IDX = 8'h92;
	localparam logic [7:0] IRQ_STATUS_IDX = 8'h94;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h95;
	localparam logic [7:0] INPUT_STATUS_IDX = 8'h96;

	localparam logic [7:0] CARD_CONTROL_RST = 8'h00;
	localparam logic [7:0] DEVICE_CONTROL_RST = 8'h66;
	localparam logic [7:0] DEVICE_CONTROL_RO_MASK = 8'h10;

	localparam int CC_RING_BIT = 7;
	localparam int CC_AUDIO_BIT = 2;
	localparam int CC_SPEAKER_BIT = 1;
	localparam int CC_FLAG_BIT = 0;
	localparam int DC_HOLD_BIT = 7;
	localparam int DC_LOWV_BIT = 6;
	localparam int DC_DIAG_BIT = 5;
	localparam int DC_MODE_LSB = 1;

	localparam int IRQ_CARD_BIT = 0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;

	typedef enum logic [1:0] {
		MODE_PARALLEL = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_SERIRQ_PAR = 2'b10,
		MODE_SERIAL_ALL = 2'b11
	} int_mode_t;

	typedef struct packed {
		logic sel;
		logic write;
		logic [7:0] index;
	} bus_req_t;

endpackage

// file: hw/card_device_control_regs.sv
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// R1: Ring-indicate output enabled only while card control bit 7 is one.
// R2: Software keeps reserved card control bits 6..3 unchanged when writing.
// R3: Card audio routes to PWM pin when bit 2 is zero; unrouted when one.
// R4: Speaker pass-through drives output only while card control bit 1 is set.
// R5: Card functional interrupt sets card control bit 0.
// R6: Card flag clears only on write of one; zero leaves it.
// R7: Marked bits reset only by the global reset pin.
// R8: Device control bit 7 blocks socket power-down requests while in D3.
// R9: Device control bit 6 forces reported low-voltage capability, default one.
// R10: Device control bit 5 is read/write diagnostic, reset value one.
// R11: Device control bit 4 reads zero; writes ignored.
// R12: Software writes only zero to device control bit 3.
// R13: Device control bits 2:1 select interrupt signaling mode, default 11.
// R14: Software writes only zero to device control bit 0.
// R15: Reserved read/write bits return last written value or reset value.
module card_device_control_regs
	import card_regs_pkg::*;
(
	// Bus clock and resets
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic global_reset_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Card side pins
	input wire logic card_func_irq,
	input wire logic card_speaker_in,
	input wire logic card_audio_in,
	input wire logic ring_indicate_in,
	output logic ring_indicate_output,
	output logic speaker_output_pin,
	output logic speaker_output_oe,
	output logic card_audio_pwm_output,
	// Power control
	input wire logic in_d3,
	input wire logic socket_power_down_req,
	output logic socket_power_down,
	// Configuration outputs
	output logic low_voltage_socket_force,
	output logic legacy_io_diag_bit,
	output int_mode_t interrupt_signaling_select,
	output logic irq
);

	logic [1:0] irq_s1_r, irq_s2_r, spk_s1_r, spk_s2_r, aud_s1_r, aud_s2_r;
	logic irq_seen_r, irq_seen_nxt;
	logic irq_edge;
	bus_req_t req_r, req_nxt;
	logic [7:0] card_control_r, card_control_nxt;
	logic [7:0] device_control_r, device_control_nxt;
	logic [7:0] irq_status_r, irq_status_nxt;
	logic [7:0] irq_mask_r, irq_mask_nxt;
	logic [31:0] hrdata_nxt;
	logic ri_r, spk_r, spk_oe_r, aud_r, pd_r, irq_r;
	logic [7:0] wdata;
	logic do_write;

	// Card pin inputs pass two flops; first stage read only by second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_s1_r <= 2'h0;
			irq_s2_r <= 2'h0;
			spk_s1_r <= 2'h0;
			spk_s2_r <= 2'h0;
			aud_s1_r <= 2'h0;
			aud_s2_r <= 2'h0;
		end else begin
			irq_s1_r <= {ring_indicate_in, card_func_irq};
			irq_s2_r <= irq_s1_r;
			spk_s1_r <= {1'b0, card_speaker_in};
			spk_s2_r <= spk_s1_r;
			aud_s1_r <= {1'b0, card_audio_in};
			aud_s2_r <= aud_s1_r;
		end
	end

	always_comb begin
		irq_seen_nxt = irq_s2_r[0];
	end

	// R5: rising edge of card interrupt
	assign irq_edge = irq_s2_r[0] && !irq_seen_r;

	always_comb begin
		req_nxt = req_r;
		if (hready) begin
			req_nxt.sel = hsel && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
			req_nxt.write = hwrite;
			req_nxt.index = haddr[9:2];
		end
	end

	assign do_write = req_r.sel && req_r.write;
	assign wdata = hwdata[7:0];

	always_comb begin
		card_control_nxt = card_control_r;
		device_control_nxt = device_control_r;
		irq_status_nxt = irq_status_r;
		irq_mask_nxt = irq_mask_r;
		if (do_write) begin
			case (req_r.index)
				CARD_CONTROL_IDX: begin
					// R15: reserved bits 6..3 store what is written
					card_control_nxt[7:1] = wdata[7:1];
					// R6: write one clears flag, zero keeps it
					if (wdata[CC_FLAG_BIT])
						card_control_nxt[CC_FLAG_BIT] = 1'b0;
				end
				DEVICE_CONTROL_IDX: begin
					// R11: bit 4 held at zero
					device_control_nxt = wdata & ~DEVICE_CONTROL_RO_MASK;
				end
				IRQ_STATUS_IDX: begin
					irq_status_nxt = irq_status_r & ~wdata;
				end
				IRQ_MASK_IDX: begin
					irq_mask_nxt = wdata;
				end
				default: begin
				end
			endcase
		end
		// R5: set wins over a same-cycle clear
		if (irq_edge) begin
			card_control_nxt[CC_FLAG_BIT] = 1'b1;
			irq_status_nxt[IRQ_CARD_BIT] = 1'b1;
		end
	end

	always_comb begin
		hrdata_nxt = 32'h0;
		if (req_nxt.sel && !req_nxt.write) begin
			case (req_nxt.index)
				CARD_CONTROL_IDX: hrdata_nxt[7:0] = card_control_nxt;
				DEVICE_CONTROL_IDX: hrdata_nxt[7:0] = device_control_nxt;
				IRQ_STATUS_IDX: hrdata_nxt[7:0] = irq_status_nxt;
				IRQ_MASK_IDX: hrdata_nxt[7:0] = irq_mask_nxt;
				INPUT_STATUS_IDX: hrdata_nxt[7:0] = {6'h0, irq_s2_r};
				default: hrdata_nxt = 32'h0;
			endcase
		end else begin
			hrdata_nxt = hrdata;
		end
	end

	// R7: card and device control loaded with reset values only by the global reset pin
	always_ff @(posedge hclk or negedge global_reset_n) begin
		if (!global_reset_n) begin
			card_control_r <= CARD_CONTROL_RST;
			device_control_r <= DEVICE_CONTROL_RST;
		end else begin
			card_control_r <= card_control_nxt;
			device_control_r <= device_control_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_r <= '0;
			irq_seen_r <= 1'b0;
			irq_status_r <= 8'h0;
			irq_mask_r <= 8'h0;
			hrdata <= 32'h0;
		end else begin
			req_r <= req_nxt;
			irq_seen_r <= irq_seen_nxt;
			irq_status_r <= irq_status_nxt;
			irq_mask_r <= irq_mask_nxt;
			hrdata <= hrdata_nxt;
		end
	end

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ri_r <= 1'b0;
			spk_r <= 1'b0;
			spk_oe_r <= 1'b0;
			aud_r <= 1'b0;
			pd_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			// R1: ring output gated by enable
			ri_r <= card_control_r[CC_RING_BIT] && irq_s2_r[1];
			// R4: speaker driven only when enabled
			spk_oe_r <= card_control_r[CC_SPEAKER_BIT];
			spk_r <= card_control_r[CC_SPEAKER_BIT] && spk_s2_r[0];
			// R3: audio to PWM pin only when bit is zero
			aud_r <= !card_control_r[CC_AUDIO_BIT] && aud_s2_r[0];
			// R8: power hold blocks power-down in D3
			pd_r <= socket_power_down_req && !(in_d3 && device_control_r[DC_HOLD_BIT]);
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	assign ring_indicate_output = ri_r;
	assign speaker_output_pin = spk_r;
	assign speaker_output_oe = spk_oe_r;
	assign card_audio_pwm_output = aud_r;
	assign socket_power_down = pd_r;
	assign irq = irq_r;
	// R9: low-voltage force from register
	assign low_voltage_socket_force = device_control_r[DC_LOWV_BIT];
	// R10: diagnostic bit from register
	assign legacy_io_diag_bit = device_control_r[DC_DIAG_BIT];
	// R13: mode field drives signaling select
	assign interrupt_signaling_select = int_mode_t'(device_control_r[DC_MODE_LSB +: 2]);

	// Checks skip the cycles where either reset is low
	flag_set_a: assert property (@(posedge hclk) // R5
		disable iff (!hresetn || !global_reset_n)
		irq_edge |=> card_control_r[CC_FLAG_BIT])
		else $error("card flag not set");
	flag_hold_a: assert property (@(posedge hclk) // R6
		disable iff (!hresetn || !global_reset_n)
		card_control_r[CC_FLAG_BIT] && !(do_write && req_r.index == CARD_CONTROL_IDX)
		|=> card_control_r[CC_FLAG_BIT])
		else $error("card flag lost");
	flag_clear_a: assert property (@(posedge hclk) // R6
		disable iff (!hresetn || !global_reset_n)
		do_write && req_r.index == CARD_CONTROL_IDX && wdata[CC_FLAG_BIT] && !irq_edge
		|=> !card_control_r[CC_FLAG_BIT])
		else $error("card flag not cleared");
	irq_level_a: assert property (@(posedge hclk) // R5
		disable iff (!hresetn || !global_reset_n)
		irq_status_r[IRQ_CARD_BIT] && irq_mask_r[IRQ_CARD_BIT]
		&& !(do_write && req_r.index == IRQ_STATUS_IDX) |=> irq)
		else $error("card interrupt not raised");

	ring_gate_a: assert property (@(posedge hclk) // R1
		disable iff (!hresetn || !global_reset_n)
		!card_control_r[CC_RING_BIT] |=> !ring_indicate_output)
		else $error("ring out while disabled");
	ring_pass_a: assert property (@(posedge hclk) // R1
		disable iff (!hresetn || !global_reset_n)
		card_control_r[CC_RING_BIT] && irq_s2_r[1] |=> ring_indicate_output)
		else $error("ring not passed while enabled");

	// Output flops clear on bus reset, so the cycle after release is skipped
	spk_drive_a: assert property (@(posedge hclk) // R4
		disable iff (!hresetn || !global_reset_n)
		hresetn && $past(hresetn)
		|-> speaker_output_oe == $past(card_control_r[CC_SPEAKER_BIT]))
		else $error("speaker enable mismatch");
	spk_pass_a: assert property (@(posedge hclk) // R4
		disable iff (!hresetn || !global_reset_n)
		card_control_r[CC_SPEAKER_BIT] && spk_s2_r[0] |=> speaker_output_pin)
		else $error("speaker not passed while enabled");
	spk_quiet_a: assert property (@(posedge hclk) // R4
		disable iff (!hresetn || !global_reset_n)
		!speaker_output_oe |-> !speaker_output_pin)
		else $error("speaker data while not driving");
	audio_route_a: assert property (@(posedge hclk) // R3
		disable iff (!hresetn || !global_reset_n)
		$past(card_control_r[CC_AUDIO_BIT]) |-> !card_audio_pwm_output)
		else $error("audio routed while off");
	audio_pass_a: assert property (@(posedge hclk) // R3
		disable iff (!hresetn || !global_reset_n)
		!card_control_r[CC_AUDIO_BIT] && aud_s2_r[0] |=> card_audio_pwm_output)
		else $error("audio not routed while on");

	power_hold_a: assert property (@(posedge hclk) // R8
		disable iff (!hresetn || !global_reset_n)
		in_d3 && device_control_r[DC_HOLD_BIT] |=> !socket_power_down)
		else $error("socket powered down in D3");
	power_pass_a: assert property (@(posedge hclk) // R8
		disable iff (!hresetn || !global_reset_n)
		hresetn && socket_power_down_req && !in_d3 |=> socket_power_down)
		else $error("power-down request dropped");

	bit4_zero_a: assert property (@(posedge hclk) // R11
		disable iff (!hresetn || !global_reset_n)
		(device_control_r & DEVICE_CONTROL_RO_MASK) == 8'h00)
		else $error("device bit 4 not zero");
	mode_out_a: assert property (@(posedge hclk) // R13
		disable iff (!hresetn || !global_reset_n)
		do_write && req_r.index == DEVICE_CONTROL_IDX
		|=> interrupt_signaling_select == int_mode_t'($past(wdata[DC_MODE_LSB +: 2])))
		else $error("mode not written");
	dc_store_a: assert property (@(posedge hclk) // R15
		disable iff (!hresetn || !global_reset_n)
		do_write && req_r.index == DEVICE_CONTROL_IDX
		|=> device_control_r[7:5] == $past(wdata[7:5])
		&& device_control_r[3:0] == $past(wdata[3:0]))
		else $error("device control not stored");
	keep_rsvd_a: assert property (@(posedge hclk) // R15
		disable iff (!hresetn || !global_reset_n)
		do_write && req_r.index == CARD_CONTROL_IDX
		|=> card_control_r[6:3] == $past(wdata[6:3]))
		else $error("reserved bits not kept");
	read_cc_a: assert property (@(posedge hclk) // R15
		disable iff (!hresetn || !global_reset_n)
		req_r.sel && !req_r.write && req_r.index == CARD_CONTROL_IDX
		|-> hrdata[7:0] == card_control_r)
		else $error("card control read mismatch");
	read_dc_a: assert property (@(posedge hclk) // R11
		disable iff (!hresetn || !global_reset_n)
		req_r.sel && !req_r.write && req_r.index == DEVICE_CONTROL_IDX
		|-> hrdata[7:0] == device_control_r)
		else $error("device control read mismatch");

	flag_cov: cover property (@(posedge hclk) irq_edge ##1 irq);
	clear_cov: cover property (@(posedge hclk)
		do_write && req_r.index == CARD_CONTROL_IDX && wdata[CC_FLAG_BIT]);
	hold_cov: cover property (@(posedge hclk)
		in_d3 && socket_power_down_req && device_control_r[DC_HOLD_BIT]);
	speaker_cov: cover property (@(posedge hclk) speaker_output_oe && speaker_output_pin);
	collide_cov: cover property (@(posedge hclk)
		irq_edge && do_write && req_r.index == CARD_CONTROL_IDX && wdata[CC_FLAG_BIT]);

endmodule

// file: sim/card_model.sv
`timescale 1ns/1ns
module card_model (
	// Clock and commands
	input wire logic hclk,
	input wire logic fire,
	input wire logic lvl,
	// Card pins
	output logic card_func_irq,
	output logic card_speaker_in,
	output logic card_audio_in,
	output logic ring_indicate_in
);
	logic [2:0] cnt_r = 3'h0;
	// Held several cycles so the synchronizer cannot miss it
	always @(posedge hclk) begin
		if (fire)
			cnt_r <= 3'h6;
		else if (cnt_r != 3'h0)
			cnt_r <= cnt_r - 3'h1;
	end
	assign card_func_irq = (cnt_r != 3'h0);
	assign card_speaker_in = lvl;
	assign card_audio_in = lvl;
	assign ring_indicate_in = lvl;
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top import card_regs_pkg::*;;
	logic hclk = 0, hresetn = 0, global_reset_n = 0, hsel = 0, hwrite = 0;
	logic in_d3 = 0, req = 0, fire = 0, lvl = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, cirq, spk, aud, ring, ring_o, spk_o, spk_oe, pwm, pdn, lowv, diag, irq;
	int_mode_t mode;
	int n_fail = 0, num_checks = 0;
	always #50 hclk = ~hclk;
	card_model card (.hclk(hclk), .fire(fire), .lvl(lvl), .card_func_irq(cirq),
		.card_speaker_in(spk), .card_audio_in(aud), .ring_indicate_in(ring));
	card_device_control_regs DUT (.hclk(hclk), .hresetn(hresetn),
		.global_reset_n(global_reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .card_func_irq(cirq),
		.card_speaker_in(spk), .card_audio_in(aud), .ring_indicate_in(ring),
		.ring_indicate_output(ring_o), .speaker_output_pin(spk_o),
		.speaker_output_oe(spk_oe), .card_audio_pwm_output(pwm), .in_d3(in_d3),
		.socket_power_down_req(req), .socket_power_down(pdn),
		.low_voltage_socket_force(lowv), .legacy_io_diag_bit(diag),
		.interrupt_signaling_select(mode), .irq(irq));
	task complete_run;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wait_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 20) begin
				n_fail++;
				complete_run;
			end
			@(posedge hclk);
		end
	endtask
	task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask
	task wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask
	task rdc(input string name, input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(name, exp, rd);
	endtask
	task pause(input int n);
		repeat (n) @(posedge hclk);
	endtask
	initial begin
		pause(10);
		hresetn <= 1'b1;
		global_reset_n <= 1'b1;
		pause(1);
		rdc("cc", CARD_CONTROL_IDX, 32'h00);
		rdc("dc", DEVICE_CONTROL_IDX, 32'h66);
		chk("mode", 32'h3, {30'h0, mode});
		chk("lowv", 32'h1, {31'h0, lowv});
		chk("diag", 32'h1, {31'h0, diag});
		wr(DEVICE_CONTROL_IDX, 32'hf6);
		rdc("dc", DEVICE_CONTROL_IDX, 32'he6);
		for (int m = 0; m < 4; m++) begin
			wr(DEVICE_CONTROL_IDX, 32'(m * 2));
			pause(1);
			chk("mode", 32'(m), {30'h0, mode});
			chk("lowv", 32'h0, {31'h0, lowv});
		end
		in_d3 <= 1'b1;
		req <= 1'b1;
		pause(3);
		chk("pdn", 32'h1, {31'h0, pdn});
		wr(DEVICE_CONTROL_IDX, 32'h86);
		pause(3);
		chk("pdn", 32'h0, {31'h0, pdn});
		in_d3 <= 1'b0;
		pause(3);
		chk("pdn", 32'h1, {31'h0, pdn});
		req <= 1'b0;
		lvl <= 1'b1;
		wr(CARD_CONTROL_IDX, 32'h80);
		pause(4);
		chk("ring", 32'h1, {31'h0, ring_o});
		chk("pwm", 32'h1, {31'h0, pwm});
		chk("oe", 32'h0, {31'h0, spk_oe});
		rdc("inputs", INPUT_STATUS_IDX, 32'h02);
		wr(CARD_CONTROL_IDX, 32'h06);
		pause(4);
		chk("ring", 32'h0, {31'h0, ring_o});
		chk("pwm", 32'h0, {31'h0, pwm});
		chk("spk", 32'h3, {30'h0, spk_oe, spk_o});
		fire <= 1'b1;
		pause(1);
		fire <= 1'b0;
		pause(8);
		rdc("flag", CARD_CONTROL_IDX, 32'h07);
		wr(CARD_CONTROL_IDX, 32'h06);
		rdc("flag", CARD_CONTROL_IDX, 32'h07);
		rdc("status", IRQ_STATUS_IDX, 32'h01);
		wr(IRQ_MASK_IDX, 32'h01);
		pause(2);
		chk("irq", 32'h1, {31'h0, irq});
		wr(CARD_CONTROL_IDX, 32'h07);
		rdc("flag", CARD_CONTROL_IDX, 32'h06);
		wr(IRQ_STATUS_IDX, 32'h01);
		pause(2);
		chk("irq", 32'h0, {31'h0, irq});
		hresetn <= 1'b0;
		pause(1);
		hresetn <= 1'b1;
		pause(1);
		rdc("cc", CARD_CONTROL_IDX, 32'h06);
		rdc("dc", DEVICE_CONTROL_IDX, 32'h86);
		global_reset_n <= 1'b0;
		pause(1);
		global_reset_n <= 1'b1;
		pause(1);
		rdc("cc", CARD_CONTROL_IDX, 32'h00);
		rdc("dc", DEVICE_CONTROL_IDX, 32'h66);
		rdc("unmapped", 8'h10, 32'h0);
		complete_run;
	end
endmodule
